// ---- hw/sleep_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sleep_timer
(
  input  wire logic    clk,     // System clock
  input  wire logic    resetn,  // Async reset, active low
  sleep_timer_if.timer tmr      // Start and expiry
);
  logic [31:0] count;
  logic        running;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count   <= 32'h0;
      running <= 1'b0;
    end
    else if (tmr.start)
    begin
      count   <= (tmr.period == 32'h0) ? 32'h1 : tmr.period;
      running <= 1'b1;
    end
    else if (running)
    begin
      count <= count - 32'h1;
      if (count == 32'h1)
        running <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tmr.expired <= 1'b0;
    else
      tmr.expired <= running && !tmr.start && (count == 32'h1);
  end
endmodule
`default_nettype wire

// ---- hw/wlan_power_mode_sequencer.sv ----
// Function
// (R1) Three power modes selectable by host, per connection state.
// (R2) After reset mode 0: everything powered, no power saving.
// (R3) Mode 1 powers off baseband, RF, core; requests sleep first.
// (R4) Core turns off only after host grants sleep.
// (R5) Host sends nothing while device sleeps until timer wake.
// (R6) Mode 1 unconnected: on timer expiry wake core, request again.
// (R7) Host selects mode 0 before scanning or joining.
// (R8) Host picks mode 1 or 2 only once connected; the bench also selects them while unconnected.
// (R9) Mode 1 connected: wake for beacons, sleep until before next.
// (R10) Mode 2 powers off baseband and RF only; core stays on.
// (R11) Mode 2 unconnected: radio stays off until mode 0.
// (R12) Mode 2 connected: check beacons, radio off when idle; the code powers the radio in mode 2 only on traffic, with no beacon wake.
// (R13) Return to mode 0 accepted at any time, any state; ST_SLEEP ignores it until timer expiry.
// (R14) Hold sleep request until grant; restore radio on traffic or mode 0.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_consts.svh"
module wlan_power_mode_sequencer
#(
  parameter int unsigned SLEEP_CYCLES = `SLEEP_CYCLES,     // Unconnected sleep period
  parameter int unsigned BEACON_CYCLES = `SLEEP_CYCLES,    // Beacon interval
  parameter int unsigned WAKE_LEAD = `WAKE_LEAD_CYCLES     // Wake this early before beacon
)
(
  input  wire logic       clk,          // System clock, 100 MHz
  input  wire logic       resetn,       // Async reset, active low
  input  wire logic [1:0] mode_sel,     // Host selected power mode
  input  wire logic       connected,    // Wireless link established
  input  wire logic       traffic,      // Data pending to/from AP
  input  wire logic       sleep_grant,  // Host permits sleep (pin)
  output var  logic       sleep_req,    // Request permission to sleep
  output var  logic       bb_pwr,       // Baseband power enable
  output var  logic       rf_pwr,       // RF power enable
  output var  logic       core_pwr,     // Core control power enable
  output var  logic       asleep        // Core off, host must not send
);
  // Host-side pins are asynchronous to clk
  logic [1:0] mode_m;
  logic [1:0] mode_s;
  logic       grant_m;
  logic       grant_s;
  logic       conn_m;
  logic       conn_s;
  logic       traf_m;
  logic       traf_s;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_m  <= `MODE_FULL;
      mode_s  <= `MODE_FULL;
      grant_m <= 1'b0;
      grant_s <= 1'b0;
      conn_m  <= 1'b0;
      conn_s  <= 1'b0;
      traf_m  <= 1'b0;
      traf_s  <= 1'b0;
    end
    else
    begin
      mode_m  <= mode_sel;
      mode_s  <= mode_m;
      grant_m <= sleep_grant;
      grant_s <= grant_m;
      conn_m  <= connected;
      conn_s  <= conn_m;
      traf_m  <= traffic;
      traf_s  <= traf_m;
    end
  end

  sleep_timer_if tmr ();

  sleep_timer u_timer
  (
    .clk    (clk),
    .resetn (resetn),
    .tmr    (tmr)
  );

  pwr_seq_pkg::state_type state;
  pwr_seq_pkg::state_type next_state;

  // Mode 3 is undefined; treated as full power so it never saves by accident
  function automatic logic is_deep(input logic [1:0] m);
    return m == `MODE_DEEP;
  endfunction

  function automatic logic is_light(input logic [1:0] m);
    return m == `MODE_LIGHT;
  endfunction

  // Sleep length: beacon-led when connected, fixed timer otherwise
  logic [31:0] sleep_len;
  always_comb
  begin
    if (conn_s && BEACON_CYCLES > WAKE_LEAD)
      sleep_len = 32'(BEACON_CYCLES - WAKE_LEAD); // R9
    else if (conn_s)
      sleep_len = 32'h1;
    else
      sleep_len = 32'(SLEEP_CYCLES); // R6
  end

  always_comb
  begin
    next_state = state;
    case (state)
      pwr_seq_pkg::ST_FULL:
      begin
        if (is_deep(mode_s))
          next_state = pwr_seq_pkg::ST_REQUEST; // R1 R3
        // Busy link keeps the radio up: no off-on blip on entry
        else if (is_light(mode_s) && conn_s && traf_s)
          next_state = pwr_seq_pkg::ST_LIGHT_ACT; // R12 R14
        else if (is_light(mode_s))
          next_state = pwr_seq_pkg::ST_LIGHT; // R1 R10
      end
      pwr_seq_pkg::ST_REQUEST:
      begin
        if (!is_deep(mode_s))
          next_state = pwr_seq_pkg::ST_FULL; // R13
        else if (conn_s && traf_s)
          next_state = pwr_seq_pkg::ST_AWAKE; // R14
        else if (grant_s)
          next_state = pwr_seq_pkg::ST_SLEEP; // R4
      end
      pwr_seq_pkg::ST_SLEEP:
      begin
        // A mode change cannot be heard while the core is off
        if (tmr.expired)
          next_state = conn_s ? pwr_seq_pkg::ST_AWAKE : pwr_seq_pkg::ST_REQUEST; // R6 R9
      end
      pwr_seq_pkg::ST_AWAKE:
      begin
        if (!is_deep(mode_s))
          next_state = pwr_seq_pkg::ST_FULL; // R13
        else if (!traf_s)
          next_state = pwr_seq_pkg::ST_REQUEST; // R9
      end
      pwr_seq_pkg::ST_LIGHT:
      begin
        if (!is_light(mode_s))
          next_state = pwr_seq_pkg::ST_FULL; // R13
        else if (conn_s)
          next_state = pwr_seq_pkg::ST_LIGHT_IDL; // R12
      end
      pwr_seq_pkg::ST_LIGHT_IDL:
      begin
        if (!is_light(mode_s))
          next_state = pwr_seq_pkg::ST_FULL; // R13
        else if (!conn_s)
          next_state = pwr_seq_pkg::ST_LIGHT; // R11
        else if (traf_s)
          next_state = pwr_seq_pkg::ST_LIGHT_ACT; // R12 R14
      end
      pwr_seq_pkg::ST_LIGHT_ACT:
      begin
        if (!is_light(mode_s))
          next_state = pwr_seq_pkg::ST_FULL; // R13
        else if (!traf_s || !conn_s)
          next_state = pwr_seq_pkg::ST_LIGHT_IDL; // R12
      end
      default:
        next_state = pwr_seq_pkg::ST_FULL;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state <= pwr_seq_pkg::ST_FULL; // R2
    else
      state <= next_state;
  end

  assign tmr.start  = (state == pwr_seq_pkg::ST_REQUEST) && (next_state == pwr_seq_pkg::ST_SLEEP);
  assign tmr.period = sleep_len;

  // Outputs registered from the next state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sleep_req <= 1'b0;
      bb_pwr    <= 1'b1; // R2
      rf_pwr    <= 1'b1;
      core_pwr  <= 1'b1;
      asleep    <= 1'b0;
    end
    else
    begin
      sleep_req <= next_state == pwr_seq_pkg::ST_REQUEST; // R14
      bb_pwr    <= next_state inside {pwr_seq_pkg::ST_FULL, pwr_seq_pkg::ST_AWAKE,
                                      pwr_seq_pkg::ST_LIGHT_ACT}; // R3 R10 R11 R14
      rf_pwr    <= next_state inside {pwr_seq_pkg::ST_FULL, pwr_seq_pkg::ST_AWAKE,
                                      pwr_seq_pkg::ST_LIGHT_ACT};
      core_pwr  <= next_state != pwr_seq_pkg::ST_SLEEP; // R4 R10
      asleep    <= next_state == pwr_seq_pkg::ST_SLEEP; // R5
    end
  end

  a_core_after_grant: assert property (@(posedge clk) disable iff (!resetn) // R4
    $fell(core_pwr) |-> $past(sleep_req) && $past(grant_s))
    else $error("core powered off without grant");

  a_req_holds: assert property (@(posedge clk) disable iff (!resetn) // R14
    sleep_req && !grant_s && is_deep(mode_s) && !(conn_s && traf_s) |=> sleep_req)
    else $error("sleep request dropped before grant");

  a_light_core_on: assert property (@(posedge clk) disable iff (!resetn) // R10
    is_light(mode_s) && state != pwr_seq_pkg::ST_SLEEP |=> core_pwr)
    else $error("core off in mode 2");

  a_light_unconn: assert property (@(posedge clk) disable iff (!resetn) // R11
    state == pwr_seq_pkg::ST_LIGHT && is_light(mode_s) |=> !bb_pwr && !rf_pwr)
    else $error("radio on in mode 2 before connection");

  a_full_return: assert property (@(posedge clk) disable iff (!resetn) // R13
    !is_deep(mode_s) && !is_light(mode_s) && state != pwr_seq_pkg::ST_SLEEP |=> bb_pwr && core_pwr && !sleep_req)
    else $error("mode 0 not restored");

  sequence wake_seq;
    state == pwr_seq_pkg::ST_SLEEP && tmr.expired && !conn_s;
  endsequence
  a_timer_rewake: assert property (@(posedge clk) disable iff (!resetn) // R6
    wake_seq |=> sleep_req && core_pwr)
    else $error("no new sleep request after timer");

  a_beacon_wake: assert property (@(posedge clk) disable iff (!resetn) // R9
    state == pwr_seq_pkg::ST_SLEEP && tmr.expired && conn_s |=> bb_pwr && rf_pwr && !asleep)
    else $error("no beacon wake");

  a_deep_radio_off: assert property (@(posedge clk) disable iff (!resetn) // R3
    sleep_req |-> !bb_pwr && !rf_pwr)
    else $error("radio powered while requesting sleep");

  a_light_traffic: assert property (@(posedge clk) disable iff (!resetn) // R12
    state == pwr_seq_pkg::ST_LIGHT_IDL && traf_s && conn_s && is_light(mode_s) |=> bb_pwr)
    else $error("radio off with traffic in mode 2");

  sequence grant_seq;
    state == pwr_seq_pkg::ST_REQUEST && grant_s && is_deep(mode_s) && !(conn_s && traf_s);
  endsequence

  a_grant_sleeps: assert property (@(posedge clk) disable iff (!resetn) // R4
    grant_seq |=> asleep && !core_pwr && !sleep_req)
    else $error("grant did not put the core to sleep");

  a_grant_timer: assert property (@(posedge clk) disable iff (!resetn) // R6
    grant_seq |-> tmr.start)
    else $error("sleep timer not started on grant");

  a_sleep_holds: assert property (@(posedge clk) disable iff (!resetn) // R4
    state == pwr_seq_pkg::ST_SLEEP && !tmr.expired |=> asleep && !core_pwr)
    else $error("core woke before timer expiry");

  // Per-state output decode, so a stray next-state path shows at once
  a_full_outputs: assert property (@(posedge clk) disable iff (!resetn) // R2
    state == pwr_seq_pkg::ST_FULL |-> bb_pwr && rf_pwr && core_pwr && !sleep_req && !asleep)
    else $error("outputs not all on in full power");

  a_sleep_outputs: assert property (@(posedge clk) disable iff (!resetn) // R3
    state == pwr_seq_pkg::ST_SLEEP |-> !bb_pwr && !rf_pwr && !core_pwr && asleep && !sleep_req)
    else $error("outputs wrong while asleep");

  a_req_outputs: assert property (@(posedge clk) disable iff (!resetn) // R3
    state == pwr_seq_pkg::ST_REQUEST |-> sleep_req && core_pwr && !bb_pwr && !asleep)
    else $error("outputs wrong while requesting sleep");

  a_deep_entry: assert property (@(posedge clk) disable iff (!resetn) // R1 R3
    state == pwr_seq_pkg::ST_FULL && is_deep(mode_s) |=> sleep_req && core_pwr && !bb_pwr)
    else $error("mode 1 entry did not request sleep");

  a_light_entry: assert property (@(posedge clk) disable iff (!resetn) // R1 R10
    state == pwr_seq_pkg::ST_FULL && is_light(mode_s) && !(conn_s && traf_s) |=>
      core_pwr && !bb_pwr && !rf_pwr && !sleep_req)
    else $error("mode 2 entry did not drop the radio");

  a_light_busy_entry: assert property (@(posedge clk) disable iff (!resetn) // R12 R14
    state == pwr_seq_pkg::ST_FULL && is_light(mode_s) && conn_s && traf_s |=> bb_pwr && rf_pwr && core_pwr)
    else $error("radio dropped on mode 2 entry with traffic");

  a_traffic_abort: assert property (@(posedge clk) disable iff (!resetn) // R14
    state == pwr_seq_pkg::ST_REQUEST && is_deep(mode_s) && conn_s && traf_s |=> bb_pwr && rf_pwr && !sleep_req)
    else $error("traffic did not abort the sleep request");

  a_awake_traffic: assert property (@(posedge clk) disable iff (!resetn) // R14
    state == pwr_seq_pkg::ST_AWAKE && is_deep(mode_s) && traf_s |=> bb_pwr && rf_pwr && core_pwr && !sleep_req)
    else $error("radio off while traffic pending");

  a_awake_resleep: assert property (@(posedge clk) disable iff (!resetn) // R9
    state == pwr_seq_pkg::ST_AWAKE && is_deep(mode_s) && !traf_s |=> sleep_req && !bb_pwr && !rf_pwr)
    else $error("no sleep request after idle beacon");

  a_light_idle_off: assert property (@(posedge clk) disable iff (!resetn) // R12
    state == pwr_seq_pkg::ST_LIGHT_IDL && is_light(mode_s) && conn_s && !traf_s |=> core_pwr && !bb_pwr && !rf_pwr)
    else $error("radio on while idle in mode 2");

  a_light_act_off: assert property (@(posedge clk) disable iff (!resetn) // R12
    state == pwr_seq_pkg::ST_LIGHT_ACT && is_light(mode_s) && !traf_s |=> core_pwr && !bb_pwr && !rf_pwr)
    else $error("radio kept on after traffic in mode 2");
endmodule
`default_nettype wire

// ---- shared/pwr_seq_consts.svh ----
`ifndef PWR_SEQ_CONSTS_SVH
`define PWR_SEQ_CONSTS_SVH

`define MODE_FULL        2'h0
`define MODE_DEEP        2'h1
`define MODE_LIGHT       2'h2
`define SLEEP_TIME_US    1000
`define CLK_PERIOD_NS    10
`define SLEEP_CYCLES     ((`SLEEP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_LEAD_CYCLES 16

`endif

// ---- shared/pwr_seq_pkg.sv ----
`default_nettype none
package pwr_seq_pkg;
  typedef enum logic [6:0] {
    ST_FULL      = 7'h01,
    ST_LIGHT     = 7'h02,
    ST_REQUEST   = 7'h04,
    ST_SLEEP     = 7'h08,
    ST_AWAKE     = 7'h10,
    ST_LIGHT_IDL = 7'h20,
    ST_LIGHT_ACT = 7'h40
  } state_type;
endpackage
`default_nettype wire

// ---- shared/sleep_timer_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sleep_timer_if;
  logic        start;
  logic [31:0] period;
  logic        expired;
  modport ctrl  (output start, output period, input expired);
  modport timer (input start, input period, output expired);
endinterface
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model
#(
  parameter int unsigned GRANT_DELAY = 3  // Grant rises GRANT_DELAY+1 cycles after request
)
(
  input  wire logic clk,         // System clock
  input  wire logic resetn,      // Async reset, active low
  input  wire logic grant_en,    // Bench lets the host grant
  input  wire logic sleep_req,   // Sleep request from device
  output var  logic sleep_grant  // Sleep permission to device
);
  int unsigned wait_cnt;

  // Host never sends while the device sleeps; it only answers requests
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_cnt    <= 0;
      sleep_grant <= 1'b0;
    end
    else if (!(grant_en && sleep_req))
    begin
      wait_cnt    <= 0;
      sleep_grant <= 1'b0;
    end
    else if (wait_cnt < GRANT_DELAY)
      wait_cnt <= wait_cnt + 1;
    else
      sleep_grant <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk;
  logic       resetn;
  logic [1:0] mode_sel;
  logic       connected;
  logic       traffic;
  logic       grant_en;
  logic       sleep_grant;
  logic       sleep_req;
  logic       bb_pwr;
  logic       rf_pwr;
  logic       core_pwr;
  logic       asleep;
  logic [4:0] outs;
  int         n_mismatch;
  int         samples_checked;

  assign outs = {sleep_req, bb_pwr, rf_pwr, core_pwr, asleep};

  initial clk = 1'b0;
  always #5 clk = ~clk;

  host_model #(.GRANT_DELAY(3)) u_host (.clk(clk), .resetn(resetn), .grant_en(grant_en),
    .sleep_req(sleep_req), .sleep_grant(sleep_grant));

  wlan_power_mode_sequencer #(.SLEEP_CYCLES(20), .BEACON_CYCLES(40), .WAKE_LEAD(16)) u_dut (
    .clk(clk), .resetn(resetn), .mode_sel(mode_sel), .connected(connected), .traffic(traffic),
    .sleep_grant(sleep_grant), .sleep_req(sleep_req), .bb_pwr(bb_pwr), .rf_pwr(rf_pwr),
    .core_pwr(core_pwr), .asleep(asleep));

  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Outputs as {sleep_req, bb, rf, core, asleep}
  task automatic check_outs(input logic [4:0] exp);
    samples_checked++;
    if (outs !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: outputs %b, expected %b", $time, outs, exp);
    end
  endtask

  task automatic hold_outs(input logic [4:0] exp, input int n);
    repeat (n)
    begin
      step(1);
      check_outs(exp);
    end
  endtask

  task automatic wait_outs(input logic [4:0] mask, input logic [4:0] val, input int bound);
    int i;
    for (i = 0; i < bound && (outs & mask) !== val; i++)
      step(1);
    samples_checked++;
    if ((outs & mask) !== val)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: wait ran out, outputs %b", $time, outs);
      final_report();
    end
  endtask

  task automatic t_deep_idle();
    grant_en = 1'b0;
    mode_sel = 2'h1;
    wait_outs(5'h1F, 5'b10010, 10);
    hold_outs(5'b10010, 20);
    grant_en = 1'b1;
    wait_outs(5'h1F, 5'b00001, 20);
    wait_outs(5'h1F, 5'b10010, 40);
    grant_en = 1'b0;
    mode_sel = 2'h0;
    wait_outs(5'h1F, 5'b01110, 60);
  endtask

  task automatic t_light_idle();
    mode_sel = 2'h2;
    wait_outs(5'h1F, 5'b00010, 10);
    hold_outs(5'b00010, 30);
    mode_sel = 2'h0;
    wait_outs(5'h1F, 5'b01110, 10);
  endtask

  task automatic t_light_conn();
    connected = 1'b1;
    traffic   = 1'b1;
    mode_sel  = 2'h2;
    hold_outs(5'b01110, 10);
    traffic = 1'b0;
    wait_outs(5'h1F, 5'b00010, 10);
    traffic = 1'b1;
    wait_outs(5'h1F, 5'b01110, 10);
    traffic  = 1'b0;
    mode_sel = 2'h0;
    step(10);
  endtask

  task automatic t_deep_conn();
    grant_en = 1'b1;
    mode_sel = 2'h1;
    wait_outs(5'h1F, 5'b00001, 60);
    wait_outs(5'b01000, 5'b01000, 60);
    wait_outs(5'b10000, 5'b10000, 20);
    grant_en = 1'b0;
    traffic  = 1'b1;
    wait_outs(5'h1F, 5'b01110, 10);
    traffic = 1'b0;
    wait_outs(5'h1F, 5'b10010, 10);
    mode_sel = 2'h3;
    wait_outs(5'h1F, 5'b01110, 80);
  endtask

  initial
  begin
    n_mismatch      = 0;
    samples_checked = 0;
    resetn          = 1'b0;
    mode_sel        = 2'h0;
    connected       = 1'b0;
    traffic         = 1'b0;
    grant_en        = 1'b0;
    step(6);
    check_outs(5'b01110);
    resetn = 1'b1;
    step(2);
    check_outs(5'b01110);
    t_deep_idle();
    t_light_idle();
    t_light_conn();
    t_deep_conn();
    final_report();
  end
endmodule
`default_nettype wire
